// ==== fe_cmd_pkg.sv ====
// Shared constants and types for the frontend command and fault block
package fe_cmd_pkg;

   // ----------------------------------------
   // Command and status encodings
   // ----------------------------------------
   localparam logic [7:0] OP_WRITE    = 8'h01;
   localparam logic [7:0] OP_OR_MASK  = 8'h02;
   localparam logic [7:0] OP_AND_MASK = 8'h03;
   localparam logic [7:0] STATUS_OK              = 8'h00;
   localparam logic [7:0] STATUS_INSTRUCTION_FAULT = 8'h01;

   // Notice kinds
   localparam logic [7:0] NOTE_IDLE        = 8'h01;
   localparam logic [7:0] NOTE_POWER_UP    = 8'h02;
   localparam logic [7:0] NOTE_TX_OVERCUR  = 8'h03;
   localparam logic [7:0] NOTE_CARD_DETECT = 8'h04;
   localparam logic [7:0] NOTE_AUTOCOLL    = 8'h05;

   // Notice status-word bit positions
   localparam int BIT_THERMAL_RESTART = 0;
   localparam int BIT_IO_SUPPLY_RESTART = 1;
   localparam int BIT_HOST_WAKE = 2;
   localparam int BIT_HOST_ABORT = 6;
   localparam int BIT_USER_CANCEL = 0;

   // ----------------------------------------
   // Register file layout
   // ----------------------------------------
   localparam int NUM_REGS = 16;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Attribute codes: 0 absent, 1 read-only, 2 write-only, 3 read-write
   localparam logic [1:0] ATTR_NONE = 2'h0;
   localparam logic [1:0] ATTR_RO   = 2'h1;
   localparam logic [1:0] ATTR_WO   = 2'h2;
   localparam logic [1:0] ATTR_RW   = 2'h3;
   localparam logic [31:0] ATTR_MAP = 32'h2F7F_FFFF; // Reg 11 read-only, 14 write-only, 15 absent
   localparam logic [1:0] CNT_LAST_BYTE = 2'h3;

   // Running command classes, for abort reporting
   localparam logic [1:0] RUN_NORMAL  = 2'h0;
   localparam logic [1:0] RUN_CARD_DETECT = 2'h1;
   localparam logic [1:0] RUN_STANDBY = 2'h2;
   localparam logic [1:0] RUN_AUTOCOLL = 2'h3;

   // Byte stream from the host link
   typedef struct packed {
      logic       valid;
      logic       first;
      logic [7:0] data;
   } byte_in_t;

   // Notice to the host
   typedef struct packed {
      logic        valid;
      logic [7:0]  kind;
      logic [31:0] word;
   } notice_t;

   typedef enum logic [4:0] {
      ST_OP    = 5'h01,
      ST_ADDR  = 5'h02,
      ST_DATA  = 5'h04,
      ST_EXEC  = 5'h08,
      ST_RESP  = 5'h10
   } cmd_state_t;

endpackage

// ==== fe_cmd_core.sv ====
// Register command interpreter with thermal, over-current, supply and abort handling
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Temperature at or above threshold setting forces standby.
// - Over-temperature standby drives notify pin 0 high when enabled.
// - Cooling below threshold restarts, power-up notice with thermal flag, pin low.
// - Transmitter over-current turns RF power off and sends over-current notice.
// - Tolerated over-current duration comes from the transmit regulator setting.
// - Pending responses and notices still go out after over-current shutdown.
// - Missing I/O supply forces standby.
// - Restart only when I/O supply returns; power-up notice with supply flag.
// - Card-detect-ultra and deepest sleep ignore abort command and select fall.
// - Abort notice depends on interrupted command class.
// - Write: address byte then 32-bit value, little-endian, stored in register.
// - Plain write needs existing register, read-write or write-only.
// - Set-bits: register OR mask, written back.
// - Clear-bits: register AND mask, written back.
// - Mask commands need existing read-write register.
// - Each register command answers one status byte, ok or fault.
// - Register commands raise no notice.
// - Card-detect status word bit 6 marks host abort.
module fe_cmd_core
   import fe_cmd_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire byte_in_t    CMD_IN,
   output var  logic        STATUS_VALID,
   output var  logic [7:0]  STATUS_BYTE,
   output var  notice_t     NOTICE,
   input  wire logic        NOTICE_READY,
   input  wire logic [7:0]  TEMP_NOW,
   input  wire logic [7:0]  TEMP_THRESHOLD_CFG,
   input  wire logic        OVERTEMP_PIN_NOTIFY_CFG,
   input  wire logic        TX_OVERCURRENT,
   input  wire logic [15:0] TX_REGULATOR_SETTING,
   input  wire logic        IO_SUPPLY_OK,
   input  wire logic        ABORT_CMD,
   input  wire logic        CHIP_SELECT_N,
   input  wire logic [1:0]  RUN_CLASS,
   input  wire logic        ULTRA_LOW_POWER_CARD_DETECT,
   input  wire logic        DEEPEST_SLEEP_STATE,
   input  wire logic [3:0]  REG_RD_ADDR,
   output var  logic [31:0] REG_RD_DATA,
   output var  logic        NOTIFY_PIN_0,
   output var  logic        RF_POWER_ON,
   output var  logic        STANDBY
);

   // ----------------------------------------
   // Command parser state
   // ----------------------------------------
   cmd_state_t  st_q, st_d;
   logic [7:0]  op_q, op_d;
   logic [7:0]  addr_q, addr_d;
   logic [31:0] val_q, val_d;
   logic [1:0]  cnt_q, cnt_d;
   logic        sv_q, sv_d;
   logic [7:0]  sb_q, sb_d;
   logic [31:0] regs_q [NUM_REGS];
   logic [31:0] wdata;
   logic        wen;
   logic [1:0]  attr;
   logic        exists;

   // Attribute lookup for the addressed register
   // Addresses past the register count read as absent, never as a wrapped index
   always_comb begin
      exists = addr_q < 8'(NUM_REGS);
      attr   = exists ? ATTR_MAP[addr_q[3:0]*2 +: 2] : ATTR_NONE;
   end

   // Parser and executor next state
   always_comb begin
      st_d   = st_q;
      op_d   = op_q;
      addr_d = addr_q;
      val_d  = val_q;
      cnt_d  = cnt_q;
      sv_d   = 1'b0;
      sb_d   = sb_q;
      wen    = 1'b0;
      wdata  = val_q;
      case (st_q)
         // Only a byte flagged as first may open a command
         ST_OP: begin
            if (CMD_IN.valid && CMD_IN.first) begin
               op_d = CMD_IN.data;
               st_d = ST_ADDR;
            end
         end
         // Address byte; restart the payload byte count
         ST_ADDR: begin
            if (CMD_IN.valid) begin
               addr_d = CMD_IN.data;
               cnt_d  = 2'h0;
               st_d   = ST_DATA;
            end
         end
         // Payload fills the value from its low byte up
         ST_DATA: begin
            if (CMD_IN.valid) begin
               val_d[cnt_q*8 +: 8] = CMD_IN.data;
               cnt_d = cnt_q + 2'h1;
               if (cnt_q == CNT_LAST_BYTE) begin
                  st_d = ST_EXEC;
               end
            end
         end
         // Check existence and attribute; a refusal writes nothing
         ST_EXEC: begin
            sb_d = STATUS_INSTRUCTION_FAULT;
            case (op_q)
               OP_WRITE: begin
                  if (attr == ATTR_RW || attr == ATTR_WO) begin
                     wen   = 1'b1;
                     wdata = val_q;
                     sb_d  = STATUS_OK;
                  end
               end
               OP_OR_MASK: begin
                  if (attr == ATTR_RW) begin
                     wen   = 1'b1;
                     wdata = regs_q[addr_q[3:0]] | val_q;
                     sb_d  = STATUS_OK;
                  end
               end
               OP_AND_MASK: begin
                  if (attr == ATTR_RW) begin
                     wen   = 1'b1;
                     wdata = regs_q[addr_q[3:0]] & val_q;
                     sb_d  = STATUS_OK;
                  end
               end
               default: ;
            endcase
            st_d = ST_RESP;
         end
         // Status strobe for one cycle, then ready for the next opcode
         ST_RESP: begin
            sv_d = 1'b1;
            st_d = ST_OP;
         end
         default: st_d = ST_OP;
      endcase
   end

   // Parser registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q   <= ST_OP;
         op_q   <= 8'h00;
         addr_q <= 8'h00;
         val_q  <= 32'h0000_0000;
         cnt_q  <= 2'h0;
         sv_q   <= 1'b0;
         sb_q   <= STATUS_OK;
      end else begin
         st_q   <= st_d;
         op_q   <= op_d;
         addr_q <= addr_d;
         val_q  <= val_d;
         cnt_q  <= cnt_d;
         sv_q   <= sv_d;
         sb_q   <= sb_d;
      end
   end

   // Register array; unchanged unless a command is accepted
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_q[i] <= {24'h00_0000, REG_RESET};
         end
      end else if (wen) begin
         regs_q[addr_q[3:0]] <= wdata;
      end
   end

   // ----------------------------------------
   // Fault and abort handling
   // ----------------------------------------
   logic        hot_q, hot_d;
   logic        io_lost_q, io_lost_d;
   logic        pin_q, pin_d;
   logic        rf_q, rf_d;
   logic [15:0] oc_cnt_q, oc_cnt_d;
   // Over-current notice waiting behind an earlier one
   logic        oc_note_q, oc_note_d;
   logic        oc_trip;
   logic        cs_q;
   logic        cs_fall;
   notice_t     nt_q, nt_d;
   logic        rdv_q;
   logic [31:0] rd_q;

   assign cs_fall = cs_q && !CHIP_SELECT_N;

   // Fault state and notice generation; register commands never post here
   always_comb begin
      hot_d     = hot_q;
      io_lost_d = io_lost_q;
      pin_d     = pin_q;
      rf_d      = rf_q;
      oc_cnt_d  = oc_cnt_q;
      oc_note_d = oc_note_q;
      nt_d      = nt_q;
      if (nt_q.valid && NOTICE_READY) begin
         nt_d.valid = 1'b0;
      end
      // Thermal standby entry and cooled restart
      if (!hot_q && TEMP_NOW >= TEMP_THRESHOLD_CFG) begin
         hot_d = 1'b1;
         pin_d = OVERTEMP_PIN_NOTIFY_CFG;
      end else if (hot_q && TEMP_NOW < TEMP_THRESHOLD_CFG && !nt_d.valid) begin
         hot_d = 1'b0;
         pin_d = 1'b0;
         nt_d  = '{1'b1, NOTE_POWER_UP, 32'(1) << BIT_THERMAL_RESTART};
      end
      // Supply loss holds standby until the supply returns
      if (!IO_SUPPLY_OK) begin
         io_lost_d = 1'b1;
      end else if (io_lost_q && !nt_d.valid) begin
         io_lost_d = 1'b0;
         nt_d = '{1'b1, NOTE_POWER_UP, 32'(1) << BIT_IO_SUPPLY_RESTART};
      end
      // Trip once the tolerated count is used up; RF goes off at once and
      // never waits for the host to drain an earlier notice
      oc_trip = TX_OVERCURRENT && rf_q && (oc_cnt_q >= TX_REGULATOR_SETTING);
      if (TX_OVERCURRENT && rf_q) begin
         if (oc_trip) begin
            rf_d     = 1'b0;
            oc_cnt_d = 16'h0000;
         end else begin
            oc_cnt_d = oc_cnt_q + 16'h0001;
         end
      end else if (!TX_OVERCURRENT) begin
         oc_cnt_d = 16'h0000;
         rf_d     = 1'b1;
      end
      // Over-current notice queues behind a pending one; a fresh trip beats the clear
      if ((oc_trip || oc_note_q) && !nt_d.valid) begin
         nt_d      = '{1'b1, NOTE_TX_OVERCUR, 32'h0000_0000};
         oc_note_d = oc_trip && oc_note_q;
      end else if (oc_trip) begin
         oc_note_d = 1'b1;
      end
      // Host abort; ignored in the two deepest low-power states
      if ((ABORT_CMD || cs_fall) && !ULTRA_LOW_POWER_CARD_DETECT
          && !DEEPEST_SLEEP_STATE && !nt_d.valid) begin
         // Notice word follows the class of the interrupted command
         case (RUN_CLASS)
            RUN_CARD_DETECT: nt_d = '{1'b1, NOTE_CARD_DETECT,
                                      32'(1) << BIT_HOST_ABORT};
            RUN_STANDBY:     nt_d = '{1'b1, NOTE_POWER_UP, 32'(1) << BIT_HOST_WAKE};
            RUN_AUTOCOLL:    nt_d = '{1'b1, NOTE_AUTOCOLL, 32'(1) << BIT_USER_CANCEL};
            default:         nt_d = '{1'b1, NOTE_IDLE, 32'h0000_0000};
         endcase
      end
   end

   // Fault registers
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hot_q     <= 1'b0;
         io_lost_q <= 1'b0;
         pin_q     <= 1'b0;
         rf_q      <= 1'b1;
         oc_cnt_q  <= 16'h0000;
         oc_note_q <= 1'b0;
         nt_q      <= '0;
         cs_q      <= 1'b1;
         rdv_q     <= 1'b0;
         rd_q      <= 32'h0000_0000;
      end else begin
         hot_q     <= hot_d;
         io_lost_q <= io_lost_d;
         pin_q     <= pin_d;
         rf_q      <= rf_d;
         oc_cnt_q  <= oc_cnt_d;
         oc_note_q <= oc_note_d;
         nt_q      <= nt_d;
         cs_q      <= CHIP_SELECT_N;
         rdv_q     <= hot_d | io_lost_d;
         rd_q      <= regs_q[REG_RD_ADDR];
      end
   end

   // Outputs straight from flip-flops
   assign STATUS_VALID = sv_q;
   assign STATUS_BYTE  = sb_q;
   assign NOTICE       = nt_q;
   assign NOTIFY_PIN_0 = pin_q;
   assign RF_POWER_ON  = rf_q;
   assign STANDBY      = rdv_q;
   assign REG_RD_DATA  = rd_q;

endmodule
`default_nettype wire

// ==== fe_cmd_monitor.sv ====
// Port checker for the register command and fault event block
`timescale 1ns/100ps
`default_nettype none
module fe_cmd_monitor
   import fe_cmd_pkg::*;
(
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire byte_in_t    CMD_IN,
   input wire logic        STATUS_VALID,
   input wire notice_t     NOTICE,
   input wire logic        NOTICE_READY,
   input wire logic [7:0]  TEMP_NOW,
   input wire logic [7:0]  TEMP_THRESHOLD_CFG,
   input wire logic        OVERTEMP_PIN_NOTIFY_CFG,
   input wire logic        TX_OVERCURRENT,
   input wire logic [15:0] TX_REGULATOR_SETTING,
   input wire logic        IO_SUPPLY_OK,
   input wire logic        ABORT_CMD,
   input wire logic [1:0]  RUN_CLASS,
   input wire logic        ULTRA_LOW_POWER_CARD_DETECT,
   input wire logic        DEEPEST_SLEEP_STATE,
   input wire logic        NOTIFY_PIN_0,
   input wire logic        RF_POWER_ON,
   input wire logic        STANDBY
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Opcode taken while idle, then address and four value bytes
   sequence cmd_frame;
      CMD_IN.valid && CMD_IN.first && !STATUS_VALID ##1 CMD_IN.valid [*5];
   endsequence
   // Status answer and its one-cycle strobe
   frame_answer_a: assert property (cmd_frame |-> ##3 STATUS_VALID)
      else $error("no status after command frame");
   status_pulse_a: assert property (STATUS_VALID |=> !STATUS_VALID)
      else $error("status strobe too long");
   reg_quiet_a: assert property (cmd_frame |=> !$rose(NOTICE.valid) [*3])
      else $error("notice raised by register command");
   // Thermal and supply standby
   heat_standby_a: assert property (TEMP_NOW >= TEMP_THRESHOLD_CFG |-> ##[1:2] STANDBY)
      else $error("no standby at threshold");
   heat_pin_a: assert property
      (TEMP_NOW >= TEMP_THRESHOLD_CFG && OVERTEMP_PIN_NOTIFY_CFG |-> ##[1:2] NOTIFY_PIN_0)
      else $error("notify pin not raised");
   io_standby_a: assert property (!IO_SUPPLY_OK |-> ##[1:2] STANDBY)
      else $error("no standby on supply loss");
   // Over-current tolerance and shutdown
   ovc_tolerate_a: assert property
      ($rose(TX_OVERCURRENT) && TX_REGULATOR_SETTING >= 16'h0004 |=> RF_POWER_ON [*3])
      else $error("RF cut before tolerance");
   ovc_off_a: assert property
      ((TX_OVERCURRENT && TX_REGULATOR_SETTING <= 16'h0004) [*8] |=> !RF_POWER_ON)
      else $error("RF still on after over-current");
   // Notice holding and abort reporting
   notice_hold_a: assert property
      (NOTICE.valid && !NOTICE_READY |=> NOTICE.valid && $stable(NOTICE.kind)
       && $stable(NOTICE.word))
      else $error("pending notice lost");
   abort_card_a: assert property (ABORT_CMD && RUN_CLASS == RUN_CARD_DETECT
      && !ULTRA_LOW_POWER_CARD_DETECT && !DEEPEST_SLEEP_STATE && !NOTICE.valid
      |=> NOTICE.valid && NOTICE.kind == NOTE_CARD_DETECT && NOTICE.word[BIT_HOST_ABORT])
      else $error("wrong card detect abort notice");
   abort_block_a: assert property (ABORT_CMD && !NOTICE.valid
      && (ULTRA_LOW_POWER_CARD_DETECT || DEEPEST_SLEEP_STATE) |=> !NOTICE.valid)
      else $error("abort not ignored in low power");
endmodule
`default_nettype wire

// ==== fe_host_model.sv ====
// Host controller model: sends register commands and takes notices
`timescale 1ns/100ps
`default_nettype none
module fe_host_model
   import fe_cmd_pkg::*;
(
   input  wire logic       CLK,
   input  wire notice_t    NOTICE,
   input  wire logic       STATUS_VALID,
   input  wire logic [7:0] STATUS_BYTE,
   output var  byte_in_t   CMD_IN,
   output var  logic       NOTICE_READY
);
   logic hold = 1'b1;
   // Slow host while hold is set, prompt otherwise
   assign NOTICE_READY = NOTICE.valid && !hold;
   initial CMD_IN = '0;
   // Opcode, address, then value low byte first; idle lines change afterwards
   task automatic send(input logic [7:0] op, adr, input logic [31:0] v, output logic [7:0] st);
      logic [7:0] b[6];
      b = '{op, adr, v[7:0], v[15:8], v[23:16], v[31:24]};
      for (int i = 0; i < 6; i++) begin
         @(negedge CLK);
         CMD_IN = '{1'b1, i == 0, b[i]};
      end
      @(negedge CLK);
      CMD_IN = '{1'b0, 1'b0, ~b[5]};
      st = 8'hEE;
      for (int i = 0; i < 8 && st === 8'hEE; i++) begin
         if (STATUS_VALID === 1'b1) st = STATUS_BYTE;
         else @(negedge CLK);
      end
   endtask
endmodule
`default_nettype wire

// ==== reg_command_fault_events_bench.sv ====
// Self-checking bench for the register command and fault event block
`timescale 1ns/100ps
`default_nettype none
module reg_command_fault_events_bench;
   import fe_cmd_pkg::*;
   localparam logic [7:0] BAD = STATUS_INSTRUCTION_FAULT;
   logic CLK, RST_N, OVERTEMP_PIN_NOTIFY_CFG, TX_OVERCURRENT, IO_SUPPLY_OK, ABORT_CMD;
   logic CHIP_SELECT_N, ULTRA_LOW_POWER_CARD_DETECT, DEEPEST_SLEEP_STATE, NOTICE_READY;
   logic STATUS_VALID, NOTIFY_PIN_0, RF_POWER_ON, STANDBY;
   logic [7:0] TEMP_NOW, TEMP_THRESHOLD_CFG, STATUS_BYTE;
   logic [15:0] TX_REGULATOR_SETTING;
   logic [1:0] RUN_CLASS;
   logic [3:0] REG_RD_ADDR;
   logic [31:0] REG_RD_DATA;
   byte_in_t CMD_IN;
   notice_t NOTICE;
   int n_errors = 0;
   int comparisons = 0;
   fe_cmd_core fe_cmd_core_inst (
      .CLK                         (CLK),
      .RST_N                       (RST_N),
      .CMD_IN                      (CMD_IN),
      .STATUS_VALID                (STATUS_VALID),
      .STATUS_BYTE                 (STATUS_BYTE),
      .NOTICE                      (NOTICE),
      .NOTICE_READY                (NOTICE_READY),
      .TEMP_NOW                    (TEMP_NOW),
      .TEMP_THRESHOLD_CFG          (TEMP_THRESHOLD_CFG),
      .OVERTEMP_PIN_NOTIFY_CFG     (OVERTEMP_PIN_NOTIFY_CFG),
      .TX_OVERCURRENT              (TX_OVERCURRENT),
      .TX_REGULATOR_SETTING        (TX_REGULATOR_SETTING),
      .IO_SUPPLY_OK                (IO_SUPPLY_OK),
      .ABORT_CMD                   (ABORT_CMD),
      .CHIP_SELECT_N               (CHIP_SELECT_N),
      .RUN_CLASS                   (RUN_CLASS),
      .ULTRA_LOW_POWER_CARD_DETECT (ULTRA_LOW_POWER_CARD_DETECT),
      .DEEPEST_SLEEP_STATE         (DEEPEST_SLEEP_STATE),
      .REG_RD_ADDR                 (REG_RD_ADDR),
      .REG_RD_DATA                 (REG_RD_DATA),
      .NOTIFY_PIN_0                (NOTIFY_PIN_0),
      .RF_POWER_ON                 (RF_POWER_ON),
      .STANDBY                     (STANDBY)
   );
   fe_host_model fe_host_model_inst (
      .CLK          (CLK),
      .NOTICE       (NOTICE),
      .STATUS_VALID (STATUS_VALID),
      .STATUS_BYTE  (STATUS_BYTE),
      .CMD_IN       (CMD_IN),
      .NOTICE_READY (NOTICE_READY)
   );
   // Clock at 100 MHz
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic cmd(input logic [7:0] op, adr, input logic [31:0] v, input logic [7:0] exp);
      logic [7:0] st;
      fe_host_model_inst.send(op, adr, v, st);
      check(st, exp);
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(negedge CLK) REG_RD_ADDR = a;
      wait_n(2);
      check(REG_RD_DATA, exp);
   endtask
   // Wait for a notice, judge it, then let the host take it
   task automatic note(input logic [7:0] kind, input logic [31:0] m);
      for (int i = 0; i < 20 && NOTICE.valid !== 1'b1; i++) @(negedge CLK);
      check(NOTICE.valid, 1'b1);
      check(NOTICE.kind, kind);
      check(NOTICE.word & m, m);
      fe_host_model_inst.hold = 1'b0;
      wait_n(1);
      fe_host_model_inst.hold = 1'b1;
   endtask
   task automatic pulse_abort();
      @(negedge CLK) ABORT_CMD = 1'b1;
      @(negedge CLK) ABORT_CMD = 1'b0;
   endtask
   task automatic t_regs();
      cmd(OP_WRITE, 8'h03, 32'h1234_5678, STATUS_OK);
      rd(4'h3, 32'h1234_5678);
      cmd(OP_OR_MASK, 8'h03, 32'h0F00_0000, STATUS_OK);
      rd(4'h3, 32'h1F34_5678);
      cmd(OP_AND_MASK, 8'h03, 32'hFFFF_00FF, STATUS_OK);
      rd(4'h3, 32'h1F34_0078);
      cmd(OP_WRITE, 8'h0B, 32'hFFFF_FFFF, BAD);
      cmd(OP_OR_MASK, 8'h0B, 32'hFFFF_FFFF, BAD);
      cmd(OP_AND_MASK, 8'h0F, 32'h0000_0000, BAD);
      cmd(OP_WRITE, 8'h10, 32'hA5A5_A5A5, BAD);
      cmd(OP_WRITE, 8'h0E, 32'hC3C3_0F0F, STATUS_OK);
      cmd(OP_OR_MASK, 8'h0E, 32'hFFFF_FFFF, BAD);
      cmd(8'h07, 8'h03, 32'h0000_0000, BAD);
      rd(4'hB, 32'h0000_0000);
      rd(4'hE, 32'hC3C3_0F0F);
      rd(4'h0, 32'h0000_0000);
      rd(4'h3, 32'h1F34_0078);
      check(NOTICE.valid, 1'b0);
      $display("register commands done");
   endtask
   task automatic t_abort();
      logic [7:0] k[4];
      logic [31:0] m[4];
      k = '{NOTE_IDLE, NOTE_CARD_DETECT, NOTE_POWER_UP, NOTE_AUTOCOLL};
      m = '{32'h0, 32'h1 << BIT_HOST_ABORT, 32'h1 << BIT_HOST_WAKE, 32'h1 << BIT_USER_CANCEL};
      for (int c = 0; c < 4; c++) begin
         @(negedge CLK) RUN_CLASS = c[1:0];
         pulse_abort();
         note(k[c], m[c]);
      end
      RUN_CLASS = RUN_NORMAL;
      ULTRA_LOW_POWER_CARD_DETECT = 1'b1;
      pulse_abort();
      ULTRA_LOW_POWER_CARD_DETECT = 1'b0;
      DEEPEST_SLEEP_STATE = 1'b1;
      CHIP_SELECT_N = 1'b0;
      wait_n(3);
      check(NOTICE.valid, 1'b0);
      CHIP_SELECT_N = 1'b1;
      DEEPEST_SLEEP_STATE = 1'b0;
      wait_n(2);
      CHIP_SELECT_N = 1'b0;
      note(NOTE_IDLE, 32'h0);
      CHIP_SELECT_N = 1'b1;
      $display("abort handling done");
   endtask
   task automatic t_faults();
      @(negedge CLK) TEMP_NOW = 8'h40;
      wait_n(3);
      check(STANDBY, 1'b1);
      check(NOTIFY_PIN_0, 1'b1);
      TEMP_NOW = 8'h3F;
      note(NOTE_POWER_UP, 32'h1 << BIT_THERMAL_RESTART);
      check(NOTIFY_PIN_0, 1'b0);
      check(STANDBY, 1'b0);
      IO_SUPPLY_OK = 1'b0;
      wait_n(6);
      check(STANDBY, 1'b1);
      check(NOTICE.valid, 1'b0);
      IO_SUPPLY_OK = 1'b1;
      note(NOTE_POWER_UP, 32'h1 << BIT_IO_SUPPLY_RESTART);
      check(STANDBY, 1'b0);
      // An idle notice is still pending when the over-current trips
      pulse_abort();
      TX_OVERCURRENT = 1'b1;
      wait_n(3);
      check(RF_POWER_ON, 1'b1);
      wait_n(8);
      check(RF_POWER_ON, 1'b0);
      note(NOTE_IDLE, 32'h0);
      note(NOTE_TX_OVERCUR, 32'h0);
      TX_OVERCURRENT = 1'b0;
      wait_n(2);
      check(RF_POWER_ON, 1'b1);
      $display("fault events done");
   endtask
   // Time-zero values, reset for three cycles, then the tests
   initial begin
      RST_N = 1'b0;
      TEMP_NOW = 8'h20;
      TEMP_THRESHOLD_CFG = 8'h40;
      OVERTEMP_PIN_NOTIFY_CFG = 1'b1;
      TX_OVERCURRENT = 1'b0;
      TX_REGULATOR_SETTING = 16'h0004;
      IO_SUPPLY_OK = 1'b1;
      ABORT_CMD = 1'b0;
      CHIP_SELECT_N = 1'b1;
      RUN_CLASS = RUN_NORMAL;
      ULTRA_LOW_POWER_CARD_DETECT = 1'b0;
      DEEPEST_SLEEP_STATE = 1'b0;
      REG_RD_ADDR = 4'h0;
      wait_n(3);
      RST_N = 1'b1;
      t_regs();
      t_abort();
      t_faults();
      conclude();
   end
   // Watchdog against a hang
   initial begin
      #200us;
      n_errors++;
      conclude();
   end
endmodule
bind fe_cmd_core fe_cmd_monitor fe_cmd_monitor_inst (
   .CLK                         (CLK),
   .RST_N                       (RST_N),
   .CMD_IN                      (CMD_IN),
   .STATUS_VALID                (STATUS_VALID),
   .NOTICE                      (NOTICE),
   .NOTICE_READY                (NOTICE_READY),
   .TEMP_NOW                    (TEMP_NOW),
   .TEMP_THRESHOLD_CFG          (TEMP_THRESHOLD_CFG),
   .OVERTEMP_PIN_NOTIFY_CFG     (OVERTEMP_PIN_NOTIFY_CFG),
   .TX_OVERCURRENT              (TX_OVERCURRENT),
   .TX_REGULATOR_SETTING        (TX_REGULATOR_SETTING),
   .IO_SUPPLY_OK                (IO_SUPPLY_OK),
   .ABORT_CMD                   (ABORT_CMD),
   .RUN_CLASS                   (RUN_CLASS),
   .ULTRA_LOW_POWER_CARD_DETECT (ULTRA_LOW_POWER_CARD_DETECT),
   .DEEPEST_SLEEP_STATE         (DEEPEST_SLEEP_STATE),
   .NOTIFY_PIN_0                (NOTIFY_PIN_0),
   .RF_POWER_ON                 (RF_POWER_ON),
   .STANDBY                     (STANDBY)
);
`default_nettype wire
